/* File: core/bsrs_pkg.sv */
// constants, field layouts and types shared by the block start sequencer
package bsrs_pkg;

	// ====================================================================
	// table sizes
	localparam int POINTS = 16;
	localparam int PT_W = 4;
	localparam int ENTRIES = 64;
	localparam int EN_W = 6;
	localparam int CONDS = 8;
	localparam int CD_W = 3;
	localparam int AW = 12;

	// ====================================================================
	// register and table byte offsets
	localparam logic [AW-1:0] REG_CTRL = 12'h000;
	localparam logic [AW-1:0] REG_STATUS = 12'h004;
	localparam logic [AW-1:0] REG_WARN = 12'h008;
	localparam logic [AW-1:0] REG_FIRST = 12'h00c;
	localparam logic [AW-1:0] BASE_POINT = 12'h100;
	localparam logic [AW-1:0] BASE_PATTERN = 12'h200;
	localparam logic [AW-1:0] BASE_COND = 12'h400;
	localparam int SPAN_POINT = 6;
	localparam int SPAN_PATTERN = 8;
	localparam int SPAN_COND = 7;

	// ====================================================================
	// field positions
	localparam int CTRL_START = 0;
	localparam int PT_SHAPE = 0;
	localparam int PT_CODE_LSB = 4;
	localparam int CODE_W = 3;
	localparam int PT_ENTRY_LSB = 8;
	localparam int PT_PARAM_LSB = 16;
	localparam int PARAM_W = 16;
	localparam int CT_TGT_LSB = 0;
	localparam int CT_OP_LSB = 8;
	localparam int CT_ADDR_LSB = 16;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_WARN = 2;
	localparam int ST_TGTERR = 3;
	localparam int ST_POINT_LSB = 8;
	localparam int ST_ENTRY_LSB = 16;

	// ====================================================================
	// codes and reset values
	localparam logic SHAPE_END = 1'b0;
	localparam logic [CODE_W-1:0] CODE_BLOCK = 3'h0;
	localparam logic [CODE_W-1:0] CODE_COND_START = 3'h1;
	localparam logic [CODE_W-1:0] CODE_WAIT_START = 3'h2;
	localparam logic [CODE_W-1:0] CODE_SIM = 3'h3;
	localparam logic [CODE_W-1:0] CODE_FOR_LOOP = 3'h4;
	localparam logic [CODE_W-1:0] CODE_FOR_COND = 3'h5;
	localparam logic [CODE_W-1:0] CODE_NEXT = 3'h6;
	localparam logic [1:0] PAT_COMPLETE = 2'h0;
	localparam logic [1:0] PAT_CONT = 2'h1;
	localparam logic [1:0] PAT_PATH = 2'h3;
	localparam logic [7:0] TGT_DEV_X = 8'h01;
	localparam logic [7:0] TGT_BUF_TWO = 8'h04;
	localparam logic [7:0] TGT_POS_NUM = 8'h05;
	localparam logic [15:0] WARN_NEST = 16'h01fa;
	localparam logic [PT_W-1:0] RST_FIRST = 4'h0;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_POINT = 5'h02,
		S_COND = 5'h04,
		S_RUN = 5'h08,
		S_STEP = 5'h10
	} bsrs_state_t;

endpackage

/* File: core/bsrs_target_check.sv */
// condition target legality for each special start type
`timescale 1ns/100ps
module bsrs_target_check (
	input wire logic [bsrs_pkg::CODE_W-1:0] specialCode,
	input wire logic [7:0] target,
	output logic allowed
);
	import bsrs_pkg::*;

	// ====================================================================
	// device and buffer targets suit all but simultaneous start
	wire logic isBasic = (target >= TGT_DEV_X) && (target <= TGT_BUF_TWO);
	wire logic isPosNum = (target == TGT_POS_NUM);
	assign allowed = (specialCode == CODE_SIM) ? isPosNum : isBasic;

endmodule

/* File: core/bsrs_sequencer.sv */
// block start point sequencer with FOR/NEXT repetition and an AHB-Lite table port
//
// Functional notes
// - code 6 closes a section opened by FOR loop (4) or FOR condition (5).
// - FOR loop repeats its section parameter times; zero count loops forever.
// - FOR condition is evaluated on switching to the closing point, before its run.
// - closing point always runs; then jump back if failed, finish if held.
// - closing point with no FOR executed acts as an ordinary block start point.
// - FOR without a later closing point: no repetition and no error.
// - a second FOR while one is open raises warning 506.
// - after nesting, closing jumps to inner FOR; outer closing becomes ordinary.
// - each point runs entries from its start number while pattern is 01 or 11, stopping at entry 63.
// - condition entry holds target, operator, address, parameter one and two.
// - targets 01-04 refused for simultaneous start; 05 valid only there.
`timescale 1ns/100ps
module bsrs_sequencer (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic posStart,
	output logic [bsrs_pkg::EN_W-1:0] posEntry,
	input wire logic posDone,
	output logic condReq,
	output logic [7:0] condTarget,
	output logic [7:0] condOperator,
	output logic [15:0] condAddress,
	output logic [31:0] condParamOne,
	output logic [31:0] condParamTwo,
	input wire logic condAck,
	input wire logic condMet,
	output logic blockBusy
);
	import bsrs_pkg::*;

	// ====================================================================
	// bus slave
	function automatic logic inRegion(input logic [AW-1:0] a, input logic [AW-1:0] base, input int span);
		return (a >> span) == (base >> span);
	endfunction

	logic wrPend_ff;
	logic [AW-1:0] wrAddr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rdMux;
	wire logic addrPhase = hsel & htrans[1] & hready;
	wire logic [AW-1:0] rdAddr = haddr[AW-1:0];

	// zero wait states: writes land in the data phase, reads are captured at the address edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 12'h000;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			wrPend_ff <= addrPhase & hwrite;
			wrAddr_ff <= rdAddr;
			if (addrPhase & ~hwrite)
				hrdata_ff <= rdMux;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	wire logic wrPoint = wrPend_ff & inRegion(wrAddr_ff, BASE_POINT, SPAN_POINT);
	wire logic wrPattern = wrPend_ff & inRegion(wrAddr_ff, BASE_PATTERN, SPAN_PATTERN);
	wire logic wrCond = wrPend_ff & inRegion(wrAddr_ff, BASE_COND, SPAN_COND);
	wire logic wrCtrl = wrPend_ff & (wrAddr_ff == REG_CTRL);
	wire logic wrWarn = wrPend_ff & (wrAddr_ff == REG_WARN);
	wire logic wrFirst = wrPend_ff & (wrAddr_ff == REG_FIRST);
	wire logic [CD_W-1:0] wrCondIdx = wrAddr_ff[4 +: CD_W];
	wire logic [1:0] wrCondWord = wrAddr_ff[3:2];

	// ====================================================================
	// tables written by software; plain storage, no reset
	logic [31:0] pointTab [POINTS];
	logic [1:0] patTab [ENTRIES];
	logic [31:0] condHead [CONDS];
	logic [31:0] condP1 [CONDS];
	logic [31:0] condP2 [CONDS];

	// each condition entry carries its five fields in three words
	always_ff @(posedge core_clk) begin
		if (wrPoint)
			pointTab[wrAddr_ff[2 +: PT_W]] <= hwdata;
		if (wrPattern)
			patTab[wrAddr_ff[2 +: EN_W]] <= hwdata[1:0];
		if (wrCond && wrCondWord == 2'h0)
			condHead[wrCondIdx] <= hwdata;
		if (wrCond && wrCondWord == 2'h1)
			condP1[wrCondIdx] <= hwdata;
		if (wrCond && wrCondWord == 2'h2)
			condP2[wrCondIdx] <= hwdata;
	end

	// ====================================================================
	// sequencer state
	bsrs_state_t state_ff;
	logic [PT_W-1:0] curPoint_ff;
	logic [EN_W-1:0] curEntry_ff;
	logic [PT_W-1:0] firstPoint_ff;
	logic [PT_W-1:0] forPoint_ff;
	logic [PARAM_W-1:0] forLimit_ff;
	logic [PARAM_W-1:0] forIter_ff;
	logic [CD_W-1:0] forCondIdx_ff;
	logic forOpen_ff;
	logic forIsCond_ff;
	logic reentry_ff;
	logic jumpBack_ff;
	logic finish_ff;
	logic done_ff;
	logic warn_ff;
	logic tgtErr_ff;
	logic [31:0] condHead_ff;
	logic [31:0] condP1_ff;
	logic [31:0] condP2_ff;

	// ====================================================================
	// decode of the current point
	wire logic [31:0] ptWord = pointTab[curPoint_ff];
	wire logic ptShape = ptWord[PT_SHAPE];
	wire logic [CODE_W-1:0] ptCode = ptWord[PT_CODE_LSB +: CODE_W];
	wire logic [EN_W-1:0] ptEntry = ptWord[PT_ENTRY_LSB +: EN_W];
	wire logic [PARAM_W-1:0] ptParam = ptWord[PT_PARAM_LSB +: PARAM_W];
	wire logic [CD_W-1:0] ptCondIdx = ptParam[CD_W-1:0];
	wire logic isFor = (ptCode == CODE_FOR_LOOP) || (ptCode == CODE_FOR_COND);
	wire logic freshFor = isFor & ~reentry_ff;
	wire logic isClose = (ptCode == CODE_NEXT) & forOpen_ff;
	wire logic needsCond = (ptCode == CODE_COND_START) || (ptCode == CODE_WAIT_START) ||
		(ptCode == CODE_SIM) || (ptCode == CODE_FOR_COND);
	wire logic [7:0] ptTarget = condHead[ptCondIdx][CT_TGT_LSB +: 8];
	wire logic targetOk;
	wire logic tgtFail = needsCond & ~targetOk & ~reentry_ff;
	wire logic [PARAM_W-1:0] iterNext = forIter_ff + 16'h0001;
	wire logic loopAgain = (forLimit_ff == 16'h0000) || (iterNext < forLimit_ff);
	wire logic [1:0] entryPat = patTab[curEntry_ff];
	wire logic entryGoes = ((entryPat == PAT_CONT) || (entryPat == PAT_PATH)) && (curEntry_ff != EN_W'(ENTRIES - 1));
	wire logic lastPoint = (curPoint_ff == PT_W'(POINTS - 1));
	wire logic startCmd = wrCtrl & hwdata[CTRL_START];

	bsrs_target_check targetCheck (
		.specialCode(ptCode),
		.target(ptTarget),
		.allowed(targetOk)
	);

	// ====================================================================
	// point walk
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= S_IDLE;
			curPoint_ff <= RST_FIRST;
			curEntry_ff <= 6'h00;
			forPoint_ff <= RST_FIRST;
			forLimit_ff <= 16'h0000;
			forIter_ff <= 16'h0000;
			forCondIdx_ff <= 3'h0;
			forOpen_ff <= 1'b0;
			forIsCond_ff <= 1'b0;
			reentry_ff <= 1'b0;
			jumpBack_ff <= 1'b0;
			finish_ff <= 1'b0;
		end else begin
			unique case (state_ff)
			S_IDLE: begin
				if (startCmd) begin
					curPoint_ff <= firstPoint_ff;
					forOpen_ff <= 1'b0;
					reentry_ff <= 1'b0;
					state_ff <= S_POINT;
				end
			end
			S_POINT: begin
				reentry_ff <= 1'b0;
				curEntry_ff <= ptEntry;
				jumpBack_ff <= 1'b0;
				finish_ff <= 1'b0;
				if (tgtFail) begin
					state_ff <= S_IDLE;
				end else if (freshFor) begin
					// a newer FOR replaces the open one, so closing returns to the inner point
					forOpen_ff <= 1'b1;
					forPoint_ff <= curPoint_ff;
					forIsCond_ff <= (ptCode == CODE_FOR_COND);
					forLimit_ff <= ptParam;
					forIter_ff <= 16'h0000;
					forCondIdx_ff <= ptCondIdx;
					state_ff <= S_RUN;
				end else if (isClose && forIsCond_ff) begin
					state_ff <= S_COND;
				end else if (isClose) begin
					forIter_ff <= iterNext;
					jumpBack_ff <= loopAgain;
					forOpen_ff <= loopAgain;
					state_ff <= S_RUN;
				end else begin
					state_ff <= S_RUN;
				end
			end
			S_COND: begin
				if (condAck) begin
					jumpBack_ff <= ~condMet;
					finish_ff <= condMet;
					forOpen_ff <= ~condMet;
					state_ff <= S_RUN;
				end
			end
			S_RUN: begin
				if (posDone && entryGoes)
					curEntry_ff <= curEntry_ff + 6'h01;
				else if (posDone)
					state_ff <= S_STEP;
			end
			S_STEP: begin
				if (jumpBack_ff) begin
					curPoint_ff <= forPoint_ff;
					reentry_ff <= 1'b1;
					state_ff <= S_POINT;
				end else if (finish_ff || ptShape == SHAPE_END || lastPoint) begin
					state_ff <= S_IDLE;
				end else begin
					curPoint_ff <= curPoint_ff + 4'h1;
					state_ff <= S_POINT;
				end
			end
			endcase
		end
	end

	// ====================================================================
	// status flags: hardware set beats a software clear in the same cycle
	wire logic nestEvent = (state_ff == S_POINT) & freshFor & forOpen_ff & ~tgtFail;
	wire logic tgtEvent = (state_ff == S_POINT) & tgtFail;
	wire logic doneEvent = (state_ff == S_STEP) & ~jumpBack_ff & (finish_ff | ptShape == SHAPE_END | lastPoint);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			warn_ff <= 1'b0;
			tgtErr_ff <= 1'b0;
			done_ff <= 1'b0;
			firstPoint_ff <= RST_FIRST;
		end else begin
			warn_ff <= nestEvent | (warn_ff & ~wrWarn);
			tgtErr_ff <= tgtEvent | (tgtErr_ff & ~wrWarn);
			done_ff <= doneEvent | (done_ff & ~startCmd);
			if (wrFirst)
				firstPoint_ff <= hwdata[PT_W-1:0];
		end
	end

	// ====================================================================
	// condition entry handed to the evaluator, held steady during the request
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			condHead_ff <= 32'h0000_0000;
			condP1_ff <= 32'h0000_0000;
			condP2_ff <= 32'h0000_0000;
		end else if (state_ff == S_POINT) begin
			condHead_ff <= condHead[forCondIdx_ff];
			condP1_ff <= condP1[forCondIdx_ff];
			condP2_ff <= condP2[forCondIdx_ff];
		end
	end
	assign condReq = (state_ff == S_COND);
	assign condTarget = condHead_ff[CT_TGT_LSB +: 8];
	assign condOperator = condHead_ff[CT_OP_LSB +: 8];
	assign condAddress = condHead_ff[CT_ADDR_LSB +: 16];
	assign condParamOne = condP1_ff;
	assign condParamTwo = condP2_ff;
	assign posStart = (state_ff == S_RUN);
	assign posEntry = curEntry_ff;
	assign blockBusy = (state_ff != S_IDLE);

	// ====================================================================
	// read mux
	logic [31:0] statusWord;
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[ST_BUSY] = blockBusy;
		statusWord[ST_DONE] = done_ff;
		statusWord[ST_WARN] = warn_ff;
		statusWord[ST_TGTERR] = tgtErr_ff;
		statusWord[ST_POINT_LSB +: PT_W] = curPoint_ff;
		statusWord[ST_ENTRY_LSB +: EN_W] = curEntry_ff;
	end
	assign rdMux = (rdAddr == REG_STATUS) ? statusWord :
		(rdAddr == REG_WARN) ? {16'h0000, warn_ff ? WARN_NEST : 16'h0000} :
		(rdAddr == REG_FIRST) ? {28'h000_0000, firstPoint_ff} :
		inRegion(rdAddr, BASE_POINT, SPAN_POINT) ? pointTab[rdAddr[2 +: PT_W]] :
		inRegion(rdAddr, BASE_PATTERN, SPAN_PATTERN) ? {30'h0000_0000, patTab[rdAddr[2 +: EN_W]]} :
		(inRegion(rdAddr, BASE_COND, SPAN_COND) && rdAddr[3:2] == 2'h0) ? condHead[rdAddr[4 +: CD_W]] :
		(inRegion(rdAddr, BASE_COND, SPAN_COND) && rdAddr[3:2] == 2'h1) ? condP1[rdAddr[4 +: CD_W]] :
		(inRegion(rdAddr, BASE_COND, SPAN_COND) && rdAddr[3:2] == 2'h2) ? condP2[rdAddr[4 +: CD_W]] :
		32'h0000_0000;

	// ====================================================================
	// checks
	property p_close_evaluates;
		@(posedge core_clk) disable iff (rst)
		(state_ff == S_POINT && isClose && forIsCond_ff) |=> condReq && !posStart;
	endproperty
	a_close_evaluates: assert property (p_close_evaluates) else $error("closing point did not evaluate first");

	property p_endless_loop;
		@(posedge core_clk) disable iff (rst)
		(state_ff == S_POINT && isClose && !forIsCond_ff && forLimit_ff == 16'h0000) |=> jumpBack_ff && forOpen_ff;
	endproperty
	a_endless_loop: assert property (p_endless_loop) else $error("zero count loop did not repeat");

	property p_cond_outcome;
		@(posedge core_clk) disable iff (rst)
		(state_ff == S_COND && condAck) |=> state_ff == S_RUN && jumpBack_ff == !$past(condMet) && finish_ff == $past(condMet);
	endproperty
	a_cond_outcome: assert property (p_cond_outcome) else $error("condition outcome mishandled");

	property p_jump_target;
		@(posedge core_clk) disable iff (rst)
		(state_ff == S_STEP && jumpBack_ff) |=> state_ff == S_POINT && curPoint_ff == $past(forPoint_ff) && reentry_ff;
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("jump did not return to the FOR point");

	property p_ordinary_close;
		@(posedge core_clk) disable iff (rst)
		(state_ff == S_POINT && ptCode == CODE_NEXT && !forOpen_ff) |=> state_ff == S_RUN && !jumpBack_ff;
	endproperty
	a_ordinary_close: assert property (p_ordinary_close) else $error("lone closing point not ordinary");

	property p_nest_warn;
		@(posedge core_clk) disable iff (rst)
		nestEvent |=> warn_ff && forPoint_ff == $past(curPoint_ff);
	endproperty
	a_nest_warn: assert property (p_nest_warn) else $error("nesting warning or inner point missing");

	property p_warn_code;
		@(posedge core_clk) disable iff (rst)
		(addrPhase && !hwrite && rdAddr == REG_WARN && warn_ff && !wrWarn) |=> hrdata[15:0] == WARN_NEST;
	endproperty
	a_warn_code: assert property (p_warn_code) else $error("warning code not readable");

	property p_entry_chain;
		@(posedge core_clk) disable iff (rst)
		(state_ff == S_RUN && posDone && entryGoes) |=> state_ff == S_RUN && posEntry == $past(posEntry) + 6'h01;
	endproperty
	a_entry_chain: assert property (p_entry_chain) else $error("continuing entry did not advance");

	property p_entry_stop;
		@(posedge core_clk) disable iff (rst)
		(state_ff == S_RUN && posDone && entryPat == PAT_COMPLETE) |=> state_ff == S_STEP ##1 !posStart;
	endproperty
	a_entry_stop: assert property (p_entry_stop) else $error("complete pattern did not stop the run");

	property p_target_refused;
		@(posedge core_clk) disable iff (rst)
		tgtEvent |=> state_ff == S_IDLE && tgtErr_ff && !posStart;
	endproperty
	a_target_refused: assert property (p_target_refused) else $error("illegal condition target accepted");

	property p_shape_end;
		@(posedge core_clk) disable iff (rst)
		(state_ff == S_STEP && !jumpBack_ff && ptShape == SHAPE_END) |=> state_ff == S_IDLE && done_ff;
	endproperty
	a_shape_end: assert property (p_shape_end) else $error("end shape did not stop the block");

endmodule

/* File: testbench/tb.sv */
// self-checking bench for the block start sequencer
`timescale 1ns/100ps
module tb;
	import bsrs_pkg::*;
	logic core_clk = 0;
	logic rst = 1;
	logic hsel = 0;
	logic hwrite = 0;
	logic [31:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 0;
	logic hready;
	logic hreadyout, hresp, posStart, posDone = 0, condReq, condAck = 0, condMet = 0, blockBusy;
	logic [31:0] hrdata, condParamOne, condParamTwo, r, cP1, cP2;
	logic [5:0] posEntry;
	logic [7:0] condTarget, condOperator;
	logic [15:0] condAddress;
	logic [5:0] logq[$];
	logic [5:0] expq[$];
	logic cq[$];
	int acks[$];
	logic [1:0] pat[64];
	int n_errors = 0;
	int n_compared = 0;
	int dly = 0;
	logic lgl;

	// ====================================================================
	// design under test, single slave so its ready is the bus ready
	assign hready = hreadyout;
	bsrs_sequencer bsrs_sequencer_inst (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .posStart(posStart), .posEntry(posEntry),
		.posDone(posDone), .condReq(condReq), .condTarget(condTarget), .condOperator(condOperator),
		.condAddress(condAddress), .condParamOne(condParamOne), .condParamTwo(condParamTwo),
		.condAck(condAck), .condMet(condMet), .blockBusy(blockBusy));

	always #25 core_clk = ~core_clk;

	// ====================================================================
	// far side: engine answers after a random delay, evaluator from a queue
	always @(posedge core_clk) begin
		posDone <= 0;
		if (posStart && !posDone) begin
			if (dly == 0) begin
				posDone <= 1;
				logq.push_back(posEntry);
				dly = $urandom % 3;
			end else dly--;
		end
	end
	always @(posedge core_clk) begin
		condAck <= 0;
		if (condReq && !condAck && cq.size() > 0) begin
			condAck <= 1;
			condMet <= cq.pop_front();
			acks.push_back(logq.size());
			chk({condAddress, condOperator, condTarget}, 32'h0320_0403);
			chk(condParamOne, cP1);
			chk(condParamTwo, cP2);
		end
	end

	// ====================================================================
	// helpers
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one single AHB-Lite transfer; caller enters just after a rising edge
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task setPt(input int i, input logic sh, input int c, input int e, input int p);
		bus(1, BASE_POINT + 4 * i, {p[15:0], 2'b00, e[5:0], 1'b0, c[2:0], 3'b000, sh});
	endtask
	// expected entries of one point: chain on 01/11, stop otherwise
	task addRun(input int s);
		for (int e = s; e < 64; e++) begin
			expq.push_back(6'(e));
			if (!(pat[e] == PAT_CONT || pat[e] == PAT_PATH)) break;
		end
	endtask
	task cmp;
		foreach (expq[k]) if (k < logq.size()) chk(logq[k], expq[k]);
		expq.delete();
	endtask
	task startBlk(input int f);
		logq.delete();
		acks.delete();
		bus(1, REG_FIRST, f);
		bus(1, REG_CTRL, 1);
		repeat (2) @(posedge core_clk);
	endtask
	task runBlk(input int f, input logic [3:0] st);
		startBlk(f);
		for (int k = 0; k < 4000 && blockBusy; k++) @(posedge core_clk);
		chk(logq.size(), expq.size());
		cmp();
		bus(0, REG_STATUS, 0);
		chk(r[3:0], st);
		bus(0, REG_FIRST, 0);
		chk(r, f);
	endtask
	task print_verdict;
		if (n_errors == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		#(40000 * 50);
		n_errors++;
		print_verdict();
	end

	// ====================================================================
	// main sequence
	initial begin
		dly = $urandom(81623);
		dly = 0;
		repeat (16) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		bus(0, REG_STATUS, 0);
		chk(r, 0);
		bus(1, 32'h0000_0010, 32'hffff_ffff);
		bus(0, 32'h0000_0010, 0);
		chk(r, 0);
		// pattern table, with a random chain at 30..33 and a chain hitting 63
		for (int i = 0; i < 64; i++) begin
			pat[i] = (i == 1 || i == 2 || i == 50 || i == 62 || i == 63) ? PAT_CONT : (i == 10) ? PAT_PATH : PAT_COMPLETE;
			if (i >= 30 && i <= 33) pat[i] = 2'($urandom % 4);
			bus(1, BASE_PATTERN + 4 * i, {30'h0, pat[i]});
		end
		cP1 = $urandom;
		cP2 = $urandom;
		bus(1, BASE_COND + 80, 32'h0320_0403);
		bus(1, BASE_COND + 84, cP1);
		bus(1, BASE_COND + 88, cP2);
		bus(0, BASE_COND + 84, 0);
		chk(r, cP1);
		// counted loop of two
		setPt(0, 1, 4, 1, 2);
		setPt(1, 1, 0, 10, 0);
		setPt(2, 0, 6, 50, 0);
		repeat (2) begin
			addRun(1); addRun(10); addRun(50);
		end
		runBlk(0, 4'b0010);
		// condition loop: fails once then holds; closing point shape ignored
		setPt(0, 1, 5, 1, 5);
		setPt(2, 1, 6, 50, 0);
		setPt(3, 0, 0, 20, 0);
		cq = {1'b0, 1'b1};
		repeat (2) begin
			addRun(1); addRun(10); addRun(50);
		end
		runBlk(0, 4'b0010);
		chk(acks.size(), 2);
		chk(acks[0], 5);
		chk(acks[1], 12);
		// early closing point, then a loop with no closing point
		setPt(4, 1, 6, 30, 0);
		setPt(5, 1, 4, 10, 3);
		setPt(6, 0, 0, 62, 0);
		addRun(30); addRun(10); addRun(62);
		runBlk(4, 4'b0010);
		// nested loops raise the warning and the outer close is ordinary
		setPt(8, 1, 4, 50, 3);
		setPt(9, 1, 0, 3, 0);
		setPt(10, 1, 4, 10, 2);
		setPt(11, 1, 6, 1, 0);
		setPt(12, 0, 6, 3, 0);
		addRun(50); addRun(3);
		repeat (2) begin
			addRun(10); addRun(1);
		end
		addRun(3);
		runBlk(8, 4'b0110);
		bus(0, REG_WARN, 0);
		chk(r, 32'h0000_01fa);
		bus(1, REG_WARN, 0);
		bus(0, REG_WARN, 0);
		chk(r, 0);
		// every target against simultaneous start and condition loop
		for (int t = 1; t <= 5; t++) begin
			// condition start, wait start, simultaneous start and condition loop; code 4 needs no target
			for (int c = 1; c <= 5; c += (c == 3) ? 2 : 1) begin
				bus(1, BASE_COND + 96, {24'h0000_01, t[7:0]});
				setPt(13, 0, c, 10, 6);
				lgl = (c == 3) ? (t == 5) : (t <= 4);
				if (lgl) addRun(10);
				runBlk(13, lgl ? 4'b0010 : 4'b1000);
				bus(1, REG_WARN, 0);
			end
		end
		// zero count never ends; reset cuts it off
		setPt(0, 1, 4, 1, 0);
		setPt(2, 0, 6, 50, 0);
		startBlk(0);
		for (int k = 0; k < 3000 && logq.size() < 28; k++) @(posedge core_clk);
		repeat (4) begin
			addRun(1); addRun(10); addRun(50);
		end
		chk(blockBusy, 1);
		chk(logq.size(), 28);
		cmp();
		rst <= 1;
		@(posedge core_clk);
		#1;
		chk({blockBusy, posStart, condReq, hresp}, 0);
		rst <= 0;
		print_verdict();
	end
endmodule
